//--- rtl/drs_params.svh
// Purpose: constants of the readback and status register block
// Assumes: included by the top module only, by its bare name
// Notes:   bit positions count from the frame's least significant bit
`ifndef DRS_PARAMS_SVH
`define DRS_PARAMS_SVH

// serial frame layout
`define DRS_FRAME_BITS      6'd24
`define DRS_PEC_FRAME_BITS  6'd32
`define DRS_CNT_MAX         6'h3F
`define DRS_RW_BIT          23
`define DRS_ADDR_HI_BIT     22
`define DRS_ADDR_LO_BIT     21
`define DRS_SEL_MSB         20
`define DRS_SEL_LSB         16
`define DRS_PEC_POLY        8'h07
`define DRS_OUT_PAD         8'h00

// read select codes
`define DRS_SEL_CTL_BASE    5'h04
`define DRS_SEL_SLEW_BASE   5'h14
`define DRS_SEL_STATUS      5'h18
`define DRS_SEL_MAIN_CTL    5'h19
`define DRS_SEL_DCDC        5'h1A
`define DRS_SEL_NOP         5'h1C
`define DRS_SEL_SW_REG      5'h1D
`define DRS_NOP_WORD        24'h1CE000

// field positions inside register words
`define DRS_SLEW_EN_BIT     12
`define DRS_SLEW_RATE_MSB   6
`define DRS_SLEW_RATE_LSB   3
`define DRS_SLEW_STEP_MSB   2
`define DRS_SLEW_STEP_LSB   0
`define DRS_CTL_CUR_BIT     2
`define DRS_MAIN_STATRD_BIT 12
`define DRS_SW_TOGGLE_BIT   12

// status word: mask of flags that pull the shared fault pin, and flag bit positions
`define DRS_FAULT_MASK      16'h05FF
`define DRS_ST_TOGGLE_BIT   11
`define DRS_ST_PEC_BIT      10
`define DRS_ST_RAMP_BIT     9

`endif

//--- rtl/drs_pkg.sv
// Purpose: types shared by the readback and status register block
// Assumes: nothing
// Notes:   state codes are one-hot
package drs_pkg;
	typedef enum logic [3:0] {
		DRS_ST_IDLE   = 4'h1,
		DRS_ST_FRAME  = 4'h2,
		DRS_ST_DECODE = 4'h4,
		DRS_ST_FETCH  = 4'h8
	} drs_state_t;
endpackage : drs_pkg

//--- rtl/drs_regmem.sv
// Purpose: register storage with one write port and registered read
// Assumes: single clock, synchronous active high reset
// Notes:   read data appear one cycle after rd_en
module drs_regmem #(
	parameter int AW    = 5,
	parameter int DW    = 16,
	parameter int DEPTH = 32
) (
	input  wire logic          clk_sys,
	input  wire logic          reset,
	input  wire logic          wr_en,
	input  wire logic [AW-1:0] wr_addr,
	input  wire logic [DW-1:0] wr_data,
	input  wire logic          rd_en,
	input  wire logic [AW-1:0] rd_addr,
	output logic      [DW-1:0] rd_data
);
	typedef struct packed {
		logic [DEPTH-1:0][DW-1:0] mem;
		logic [DW-1:0]            rd;
	} drs_mem_t;

	drs_mem_t s_q;
	drs_mem_t s_d;

	if (DEPTH > (1 << AW) || DEPTH < 1 || DW < 1) begin : g_bad_geom
		$error("drs_regmem: bad geometry");
	end

	always_comb begin
		s_d = s_q;
		if (wr_en)
			s_d.mem[wr_addr] = wr_data;
		if (rd_en)
			s_d.rd = s_q.mem[rd_addr];
	end

	always_ff @(posedge clk_sys) begin
		if (reset)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign rd_data = s_q.rd;
endmodule : drs_regmem

//--- rtl/drs_top.sv
// Purpose: serial readback path, status word and slew settings
// Assumes: host pins asynchronous to clk_sys, sampled by two flops, sclk by three
// Notes:   input bits taken on falling serial clock, output bits follow
module drs_top
	import drs_pkg::*;
#(
	parameter int NUM_CH = 4
) (
	input  wire logic                 clk_sys,
	input  wire logic                 reset,
	input  wire logic                 sclk_pin,
	input  wire logic                 sync_n_pin,
	input  wire logic                 sdin_pin,
	input  wire logic                 target_addr_hi,
	input  wire logic                 target_addr_lo,
	input  wire logic [NUM_CH-1:0]    boost_flag,
	input  wire logic                 over_temp,
	input  wire logic [NUM_CH-1:0]    vout_fault,
	input  wire logic [NUM_CH-1:0]    iout_fault,
	input  wire logic [NUM_CH-1:0]    ramp_busy,
	output logic                      sdo,
	output logic                      sdo_en,
	output logic                      fault_n_out,
	output logic                      fault_n_oe,
	output logic [NUM_CH-1:0]         slew_limit_on,
	output logic [NUM_CH*4-1:0]       slew_update_rate,
	output logic [NUM_CH*3-1:0]       slew_step_size
);
	import drs_pkg::*;
	`include "drs_params.svh"

	localparam int PW = 4 * NUM_CH + 1;

	typedef struct packed {
		logic [2:0]          sclk_s;
		logic [1:0]          sync_s;
		logic [1:0]          sdin_s;
		logic [1:0][1:0]     addr_s;
		logic [1:0][PW-1:0]  det_s;
		drs_state_t          state;
		logic [5:0]          cnt;
		logic [31:0]         in_sr;
		logic [23:0]         out_sr;
		logic                rd_pend;
		logic [4:0]          rd_sel;
		logic [15:0]         out_word;
		logic                stat_sent;
		logic                pec_err;
		logic                user_tgl;
		logic                stat_on_wr;
		logic [NUM_CH-1:0]   cur_mode;
		logic [NUM_CH-1:0]   slew_en;
		logic [NUM_CH*4-1:0] slew_rate;
		logic [NUM_CH*3-1:0] slew_step;
		logic                sdo;
		logic                sdo_en;
		logic                fault_oe;
	} drs_top_t;

	drs_top_t s_q;
	drs_top_t s_d;

	logic        mem_wr;
	logic [4:0]  mem_wa;
	logic [15:0] mem_wd;
	logic        mem_rd;
	logic [15:0] mem_q;
	logic [15:0] status_w;
	logic [23:0] word_w;
	logic [4:0]  sel_w;
	logic        valid_w;
	logic        pec_bad_w;
	logic        match_w;
	logic        is_rd_w;
	logic        is_wr_w;
	logic        fall_w;

	if (NUM_CH != 4) begin : g_bad_ch
		$error("drs_top: exactly four channels supported");
	end

	function automatic logic [7:0] drs_crc8(input logic [23:0] d);
		logic [7:0] c;
		logic       fb;
		c = 8'h00;
		for (int i = 23; i >= 0; i--) begin
			fb = c[7] ^ d[i];
			c  = {c[6:0], 1'b0} ^ (fb ? `DRS_PEC_POLY : 8'h00);
		end
		return c;
	endfunction : drs_crc8

	// detector order in det_s: ramp, iout, vout, over temp, boost
	always_comb begin
		logic [NUM_CH-1:0] bst;
		logic [NUM_CH-1:0] vf;
		logic [NUM_CH-1:0] ifl;
		logic [NUM_CH-1:0] rmp;
		logic              ot;
		{rmp, ifl, vf, ot, bst} = s_q.det_s[1];
		status_w = {bst,
			s_q.user_tgl,
			s_q.pec_err,
			|rmp,
			ot,
			vf,
			ifl | (bst & s_q.cur_mode)};
	end

	always_comb begin
		fall_w    = s_q.sclk_s[2] & ~s_q.sclk_s[1];
		word_w    = (s_q.cnt == `DRS_PEC_FRAME_BITS) ? s_q.in_sr[31:8]
			: s_q.in_sr[23:0];
		sel_w     = word_w[`DRS_SEL_MSB:`DRS_SEL_LSB];
		valid_w   = (s_q.cnt == `DRS_FRAME_BITS)
			|| (s_q.cnt == `DRS_PEC_FRAME_BITS);
		pec_bad_w = (s_q.cnt == `DRS_PEC_FRAME_BITS)
			&& (drs_crc8(word_w) != s_q.in_sr[7:0]);
		match_w   = (word_w[`DRS_ADDR_HI_BIT] == s_q.addr_s[1][1])
			&& (word_w[`DRS_ADDR_LO_BIT] == s_q.addr_s[1][0]);
		is_rd_w   = (s_q.state == DRS_ST_DECODE) && valid_w && !pec_bad_w
			&& match_w && word_w[`DRS_RW_BIT];
		is_wr_w   = (s_q.state == DRS_ST_DECODE) && valid_w && !pec_bad_w
			&& match_w && !word_w[`DRS_RW_BIT];
		// status never stored; read data ignore D15:D0
		mem_wr = is_wr_w && (sel_w != `DRS_SEL_STATUS)
			&& (sel_w <= `DRS_SEL_DCDC);
		mem_wa = sel_w;
		mem_wd = word_w[15:0];
		mem_rd = is_rd_w;
	end

	always_comb begin
		int ch;
		ch = 0;
		s_d = s_q;
		s_d.sclk_s   = {s_q.sclk_s[1:0], sclk_pin};
		s_d.sync_s   = {s_q.sync_s[0], sync_n_pin};
		s_d.sdin_s   = {s_q.sdin_s[0], sdin_pin};
		s_d.addr_s   = {s_q.addr_s[0], {target_addr_hi, target_addr_lo}};
		s_d.det_s    = {s_q.det_s[0],
			{ramp_busy, iout_fault, vout_fault, over_temp, boost_flag}};
		s_d.fault_oe = |(status_w & `DRS_FAULT_MASK);
		case (s_q.state)
			DRS_ST_IDLE: begin
				if (!s_q.sync_s[1]) begin
					s_d.state     = DRS_ST_FRAME;
					s_d.cnt       = 6'h00;
					s_d.stat_sent = 1'b0;
					s_d.sdo_en    = 1'b1;
					if (s_q.stat_on_wr
						|| (s_q.rd_pend && s_q.rd_sel == `DRS_SEL_STATUS)) begin
						s_d.out_sr    = {`DRS_OUT_PAD, status_w};
						s_d.stat_sent = 1'b1;
					end else if (s_q.rd_pend)
						s_d.out_sr = {`DRS_OUT_PAD, s_q.out_word};
					else
						s_d.out_sr = '0;
					s_d.sdo     = s_d.out_sr[23];
					s_d.rd_pend = 1'b0;
				end
			end
			DRS_ST_FRAME: begin
				if (s_q.sync_s[1]) begin
					s_d.state  = DRS_ST_DECODE;
					s_d.sdo_en = 1'b0;
				end else if (fall_w) begin
					s_d.in_sr  = {s_q.in_sr[30:0], s_q.sdin_s[1]};
					s_d.out_sr = {s_q.out_sr[22:0], 1'b0};
					s_d.sdo    = s_q.out_sr[22];
					if (s_q.cnt != `DRS_CNT_MAX)
						s_d.cnt = s_q.cnt + 6'h01;
				end
			end
			DRS_ST_DECODE: begin
				s_d.state = DRS_ST_IDLE;
				if (s_q.stat_sent)
					s_d.pec_err = 1'b0;
				if (valid_w && pec_bad_w)
					s_d.pec_err = 1'b1;
				if (is_rd_w) begin
					s_d.rd_sel = sel_w;
					s_d.state  = DRS_ST_FETCH;
				end
				if (is_wr_w) begin
					ch = int'(sel_w[1:0]);
					if (sel_w[4:2] == `DRS_SEL_SLEW_BASE >> 2) begin
						s_d.slew_en[ch] = word_w[`DRS_SLEW_EN_BIT];
						s_d.slew_rate[ch*4 +: 4] =
							word_w[`DRS_SLEW_RATE_MSB:`DRS_SLEW_RATE_LSB];
						s_d.slew_step[ch*3 +: 3] =
							word_w[`DRS_SLEW_STEP_MSB:`DRS_SLEW_STEP_LSB];
					end
					if (sel_w[4:2] == `DRS_SEL_CTL_BASE >> 2)
						s_d.cur_mode[ch] = word_w[`DRS_CTL_CUR_BIT];
					if (sel_w == `DRS_SEL_MAIN_CTL)
						s_d.stat_on_wr = word_w[`DRS_MAIN_STATRD_BIT];
					if (sel_w == `DRS_SEL_SW_REG)
						s_d.user_tgl = word_w[`DRS_SW_TOGGLE_BIT];
				end
			end
			DRS_ST_FETCH: begin
				s_d.state    = DRS_ST_IDLE;
				s_d.out_word = mem_q;
				s_d.rd_pend  = 1'b1;
			end
			default: s_d.state = DRS_ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			s_q        <= '0;
			s_q.state  <= DRS_ST_IDLE;
			s_q.sclk_s <= 3'h0;
			s_q.sync_s <= 2'h3;
		end else
			s_q <= s_d;
	end

	drs_regmem #(
		.AW    (5),
		.DW    (16),
		.DEPTH (32)
	) u_mem (
		.clk_sys (clk_sys),
		.reset   (reset),
		.wr_en   (mem_wr),
		.wr_addr (mem_wa),
		.wr_data (mem_wd),
		.rd_en   (mem_rd),
		.rd_addr (sel_w),
		.rd_data (mem_q)
	);

	assign sdo              = s_q.sdo;
	assign sdo_en           = s_q.sdo_en;
	assign fault_n_out      = 1'b0;
	assign fault_n_oe       = s_q.fault_oe;
	assign slew_limit_on    = s_q.slew_en;
	assign slew_update_rate = s_q.slew_rate;
	assign slew_step_size   = s_q.slew_step;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);

	a_read_flag_pend: assert property (is_rd_w ##1 1 |=> s_q.rd_pend)
		else $error("read request did not leave a pending answer");
	a_read_sel_held: assert property (is_rd_w
		|=> s_q.rd_sel == $past(sel_w))
		else $error("read select not latched");
	a_read_no_store: assert property (is_rd_w
		|=> $stable(u_mem.s_q.mem))
		else $error("read request altered a register");
	a_answer_loaded: assert property (s_q.state == DRS_ST_IDLE
		&& !s_q.sync_s[1] && s_q.rd_pend && !s_q.stat_on_wr
		&& s_q.rd_sel != `DRS_SEL_STATUS
		|=> s_q.out_sr == {`DRS_OUT_PAD, $past(s_q.out_word)})
		else $error("previous register not shifted out");
	a_status_ro: assert property (is_wr_w
		&& sel_w == `DRS_SEL_STATUS |=> $stable(u_mem.s_q.mem))
		else $error("status register written");
	a_status_on_wr: assert property (s_q.state == DRS_ST_IDLE
		&& !s_q.sync_s[1] && s_q.stat_on_wr
		|=> s_q.out_sr[15:0] == $past(status_w))
		else $error("status not shifted during write");
	a_boost_no_fault: assert property (!status_w[`DRS_ST_PEC_BIT]
		&& status_w[8:0] == 9'h000 |=> !fault_n_oe)
		else $error("fault pin pulled without a fault");
	a_toggle_stable: assert property (
		!(is_wr_w && sel_w == `DRS_SEL_SW_REG) |=> $stable(s_q.user_tgl))
		else $error("toggle bit changed without software write");
	a_toggle_copy: assert property (is_wr_w
		&& sel_w == `DRS_SEL_SW_REG
		|=> s_q.user_tgl == $past(word_w[`DRS_SW_TOGGLE_BIT]))
		else $error("toggle bit not copied");
	a_pec_flag_set: assert property (s_q.state == DRS_ST_DECODE
		&& valid_w && pec_bad_w |=> s_q.pec_err ##1 s_q.pec_err)
		else $error("check failure not flagged");
	a_msb_first: assert property (s_q.state == DRS_ST_FRAME
		&& !s_q.sync_s[1] && fall_w |=> s_q.sdo == $past(s_q.out_sr[22]))
		else $error("output bit order wrong");

	c_read_req:  cover property (is_rd_w ##[1:5] s_q.rd_pend);
	c_pec_fail:  cover property (s_q.state == DRS_ST_DECODE && pec_bad_w);
	c_stat_wr:   cover property (s_q.stat_on_wr && s_q.sdo_en);
	c_slew_wr:   cover property (is_wr_w && sel_w == `DRS_SEL_SLEW_BASE);
endmodule : drs_top

//--- testbench/drs_host_model.sv
// Purpose: host serial master that sends frames and captures sdo
// Assumes: sclk idles high, the device takes bits on falling edges
// Notes:   released data line shows the inverse of its last bit
module drs_host_model (
	output logic      sclk_pin,
	output logic      sync_n_pin,
	output logic      sdin_pin,
	input  wire logic sdo
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		sclk_pin = 1'b1;
		sync_n_pin = 1'b1;
		sdin_pin = 1'b0;
	end
	// msb first, check byte appended when crc_on
	task automatic xfer(input logic [23:0] f, input logic crc_on,
		input logic [7:0] crc, output logic [23:0] r);
		logic [31:0] w;
		int          n;
		w = {f, crc};
		n = crc_on ? 32 : 24;
		sync_n_pin = 1'b0;
		#62;
		for (int i = 0; i < n; i++) begin
			sdin_pin = w[31-i];
			#31;
			if (i < 24) r[23-i] = sdo;
			sclk_pin = 1'b0;
			#62;
			sclk_pin = 1'b1;
			#32;
		end
		sync_n_pin = 1'b1;
		sdin_pin = ~sdin_pin;
		#100;
	endtask : xfer
endmodule : drs_host_model

//--- testbench/drs_top_tb.sv
// Purpose: self-checking bench of the readback and status block
// Assumes: host model owns the serial pins, bench drives the rest
// Notes:   register rows are written, then read back pipelined
module drs_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_sys = 1'b0;
	logic        reset = 1'b1;
	logic        sclk_pin, sync_n_pin, sdin_pin, sdo, sdo_en;
	logic        fault_n_out, fault_n_oe, over_temp;
	logic        target_addr_hi, target_addr_lo;
	logic [3:0]  boost_flag, vout_fault, iout_fault, ramp_busy;
	logic [3:0]  slew_limit_on;
	logic [15:0] slew_update_rate;
	logic [11:0] slew_step_size;
	int          err_count = 0;
	int          comparisons = 0;
	int          en_miss = 0;
	logic [20:0] rows [14] = '{21'h001234, 21'h03ABCD, 21'h040004,
		21'h064001, 21'h080FFF, 21'h0B0800, 21'h0C0555, 21'h0F0AAA,
		21'h100123, 21'h130FED, 21'h141F5B, 21'h170035, 21'h190100,
		21'h1A0005};
	always #5 clk_sys = ~clk_sys;
	// sdo must be enabled at every falling serial clock of a frame
	always @(negedge sclk_pin)
		if (!sync_n_pin && sdo_en !== 1'b1)
			en_miss++;
	drs_top #(.NUM_CH(4)) u_drs_top (.clk_sys(clk_sys), .reset(reset),
		.sclk_pin(sclk_pin), .sync_n_pin(sync_n_pin), .sdin_pin(sdin_pin),
		.target_addr_hi(target_addr_hi), .target_addr_lo(target_addr_lo),
		.boost_flag(boost_flag), .over_temp(over_temp),
		.vout_fault(vout_fault), .iout_fault(iout_fault),
		.ramp_busy(ramp_busy), .sdo(sdo), .sdo_en(sdo_en),
		.fault_n_out(fault_n_out), .fault_n_oe(fault_n_oe),
		.slew_limit_on(slew_limit_on), .slew_update_rate(slew_update_rate),
		.slew_step_size(slew_step_size));
	drs_host_model u_drs_host_model (.sclk_pin(sclk_pin),
		.sync_n_pin(sync_n_pin), .sdin_pin(sdin_pin), .sdo(sdo));
	task automatic wrap_up;
		$display("comparisons %0d err_count %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : wrap_up
	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	function automatic logic [7:0] crc8(input logic [23:0] d);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 23; i >= 0; i--) c = {c[6:0], 1'b0} ^
			((c[7] ^ d[i]) ? 8'h07 : 8'h00);
		return c;
	endfunction : crc8
	task automatic frame(input logic [23:0] f, output logic [23:0] r);
		u_drs_host_model.xfer(f, 1'b0, 8'h00, r);
	endtask : frame
	task automatic wr(input logic [20:0] sd);
		logic [23:0] r;
		frame({3'b000, sd}, r);
	endtask : wr
	// low half of the request is junk on purpose
	task automatic rdc(input string what, input logic [4:0] sel,
		input logic [15:0] exp);
		logic [23:0] r;
		frame({3'b100, sel, 16'hFFFF}, r);
		frame(24'h1CE000, r);
		chk(what, {16'h0000, exp}, {8'h00, r});
	endtask : rdc
	task automatic st(input logic [3:0] b, input logic o,
		input logic [3:0] v, input logic [3:0] i, input logic [3:0] rb);
		@(negedge clk_sys);
		boost_flag = b;
		over_temp = o;
		vout_fault = v;
		iout_fault = i;
		ramp_busy = rb;
	endtask : st
	initial begin
		#500us;
		err_count++;
		wrap_up();
	end
	initial begin
		logic [23:0] r;
		st(4'h0, 1'b0, 4'h0, 4'h0, 4'h0);
		target_addr_hi = 1'b0;
		target_addr_lo = 1'b0;
		repeat (12) @(negedge clk_sys);
		chk("reset slew", 32'h0, {slew_limit_on, slew_update_rate,
			slew_step_size});
		chk("reset pins", 32'h0, {29'h0, sdo, sdo_en, fault_n_oe});
		reset = 1'b0;
		repeat (4) @(negedge clk_sys);
		foreach (rows[k]) wr(rows[k]);
		chk("sdo idle", 32'h0, {31'h0, sdo_en});
		frame({3'b001, 5'h00, 16'hFFFF}, r); // foreign device address
		frame({3'b100, rows[0][20:16], 16'h0000}, r);
		for (int k = 1; k <= 14; k++) begin
			frame(k < 14 ? {3'b100, rows[k][20:16], 16'h0000} :
				24'h1CE000, r);
			chk("readback", {16'h0, rows[k-1][15:0]}, {8'h00, r});
		end
		chk("slew outputs", {4'h1, 16'h600B, 12'hA03}, {slew_limit_on,
			slew_update_rate, slew_step_size});
		st(4'h0, 1'b1, 4'h5, 4'hA, 4'h2);
		rdc("status", 5'h18, 16'h035A);
		chk("fault pin", 32'h2, {30'h0, fault_n_oe, fault_n_out});
		wr(21'h18FFFF);
		rdc("status ro", 5'h18, 16'h035A);
		st(4'h2, 1'b0, 4'h0, 4'h0, 4'h0);
		rdc("status", 5'h18, 16'h2000);
		chk("fault pin", 32'h0, {30'h0, fault_n_oe, fault_n_out});
		st(4'h1, 1'b0, 4'h0, 4'h0, 4'h0);
		rdc("status", 5'h18, 16'h1001);
		st(4'h0, 1'b0, 4'h0, 4'h0, 4'h0);
		wr(21'h1D1000);
		rdc("toggle", 5'h18, 16'h0800);
		wr(21'h1D0000);
		rdc("toggle", 5'h18, 16'h0000);
		u_drs_host_model.xfer(24'h009999, 1'b1, crc8(24'h009999) ^ 8'h01, r);
		chk("fault pin", 32'h2, {30'h0, fault_n_oe, fault_n_out});
		rdc("status", 5'h18, 16'h0400);
		rdc("status", 5'h18, 16'h0000);
		chk("fault pin", 32'h0, {30'h0, fault_n_oe, fault_n_out});
		rdc("data a", 5'h00, 16'h1234);
		u_drs_host_model.xfer(24'h004321, 1'b1, crc8(24'h004321), r);
		rdc("data a", 5'h00, 16'h4321);
		wr(21'h191000);
		st(4'h0, 1'b1, 4'h0, 4'h0, 4'h0);
		frame(24'h001111, r);
		chk("status on write", 32'h000100, {8'h00, r});
		frame({3'b100, 5'h00, 16'h0000}, r);
		frame(24'h1CE000, r);
		chk("blocked read", 32'h000100, {8'h00, r});
		wr(21'h190000);
		rdc("data a", 5'h00, 16'h1111);
		@(negedge clk_sys);
		target_addr_lo = 1'b1;
		repeat (4) @(negedge clk_sys);
		frame(24'h00BEEF, r); // other device, ignored
		frame(24'hA00000, r);
		frame(24'h3CE000, r);
		chk("device one", 32'h1111, {8'h00, r});
		@(negedge clk_sys);
		target_addr_lo = 1'b0;
		repeat (4) @(negedge clk_sys);
		wr(21'h191000);
		@(negedge clk_sys);
		reset = 1'b1;
		repeat (3) @(negedge clk_sys);
		chk("reset pins", 32'h0, {29'h0, sdo, sdo_en, fault_n_oe});
		reset = 1'b0;
		repeat (4) @(negedge clk_sys);
		chk("reset slew", 32'h0, {slew_limit_on, slew_update_rate,
			slew_step_size});
		rdc("after reset", 5'h00, 16'h0000);
		chk("sdo enable", 32'h0, en_miss);
		wrap_up();
	end
endmodule : drs_top_tb
